/* File: hdl/adc_port_device.sv */
// Notes on behaviour
// [R01] continuous clock bursts give identical results
// [R02] paused clock keeps shift position intact
// [R03] selected only while chip select low
// [R04] chip select tied low still works
// [R05] ready pin falls when conversion ends
// [R06] unread result: pin rises before next update
// [R07] host may use ready fall as interrupt
// [R08] output changes on falling clock edge
// [R09] deselect floats pin; ready keeps tracking
// [R10] status register holds readable ready flag
// [R11] output shifter loads from any register
// [R12] input bits go to selected register
// [R13] every access starts with command write
// [R14] after access, wait for next command
// [R15] 32 high input bits reset everything
// [R16] leading one holds command at first bit
`include "adc_port_params.svh"

module adc_port_device
   import adc_port_pkg::*;
#(
   parameter int DATA_BITS = 24
) (
   input  wire logic          clk,
   input  wire logic          reset_n,
   adc_port_if.device         port,
   input  wire logic          conv_done,
   input  wire logic          update_soon,
   input  wire logic [23:0]   conv_data,
   output logic [7:0]         mode_q,
   output logic [7:0]         filter_q,
   output logic               port_reset
);
   initial begin
      if (DATA_BITS != 24) $error("DATA_BITS must be 24");
   end

   dev_state_t  state_q;
   logic [2:0]  sclk_s_q;
   logic [1:0]  cs_s_q;
   logic [1:0]  din_s_q;
   logic        rise;
   logic        fall;
   logic        sel;
   logic [4:0]  cnt_q;
   logic [4:0]  need_q;
   logic [23:0] in_sr_q;
   logic [23:0] out_sr_q;
   logic [1:0]  rsel_q;
   logic        cread_q;
   logic [5:0]  ones_q;
   logic        rdy_n_q;
   logic [23:0] data_q;
   logic        dout_q;
   logic        resync;
   logic [4:0]  width;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; stage 1 is read only by stage 2
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sclk_s_q <= 3'h7;
         cs_s_q   <= 2'h3;
         din_s_q  <= 2'h0;
      end else begin
         sclk_s_q <= {sclk_s_q[1:0], port.sclk};
         cs_s_q   <= {cs_s_q[0], port.cs_n};
         din_s_q  <= {din_s_q[0], port.din};
      end
   end

   // a tied-low select simply leaves the port selected forever
   assign sel  = !cs_s_q[1]; // R03 R04
   assign rise = sel && !sclk_s_q[2] && sclk_s_q[1];
   assign fall = sel && sclk_s_q[2] && !sclk_s_q[1];

   // width of the register named by a command
   always_comb begin
      width = 5'h08;
      if (in_sr_q[`CMD_RSEL_HI-1 -: 2] == `RSEL_DATA) width = 5'h18;
   end

   ////////////////////////////////////////////////////////////////////////
   // run of high input bits; 32 in a row resets the port
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ones_q <= 6'h00;
      end else if (rise) begin
         ones_q <= din_s_q[1] ? ((ones_q == 6'(`RESYNC_ONES)) ? ones_q : ones_q + 6'h01) : 6'h00;
      end else if (ones_q == 6'(`RESYNC_ONES)) begin
         ones_q <= 6'h00;
      end
   end

   assign resync     = (ones_q == 6'(`RESYNC_ONES)); // R15
   assign port_reset = resync;

   ////////////////////////////////////////////////////////////////////////
   // command and transfer sequencer
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q  <= DEV_CMD;
         cnt_q    <= 5'h00;
         need_q   <= 5'h00;
         in_sr_q  <= 24'h000000;
         rsel_q   <= `RSEL_COMM_STATUS;
         cread_q  <= 1'b0;
         mode_q   <= `MODE_RESET;
         filter_q <= `FILTER_RESET;
      end else if (resync) begin
         state_q  <= DEV_CMD; // R15
         cnt_q    <= 5'h00;
         cread_q  <= 1'b0;
         mode_q   <= `MODE_RESET;
         filter_q <= `FILTER_RESET;
      end else if (rise) begin
         // position only moves on a sampled edge, so gaps are harmless
         unique case (state_q)
            DEV_CMD: begin // R13
               if (cnt_q == 5'h00 && din_s_q[1]) begin
                  cnt_q <= 5'h00; // R16
               end else if (cnt_q == 5'h07) begin
                  cnt_q   <= 5'h00;
                  rsel_q  <= in_sr_q[`CMD_RSEL_HI-1 -: 2];
                  cread_q <= in_sr_q[`CMD_CREAD_BIT-1];
                  need_q  <= width;
                  if (in_sr_q[`CMD_RSEL_HI-1 -: 2] == `RSEL_COMM_STATUS && !in_sr_q[`CMD_RNW_BIT-1])
                     state_q <= DEV_CMD;
                  else
                     state_q <= in_sr_q[`CMD_RNW_BIT-1] ? DEV_READ : DEV_WRITE;
               end else begin
                  cnt_q   <= cnt_q + 5'h01; // R01 R02
                  in_sr_q <= {in_sr_q[22:0], din_s_q[1]};
               end
            end
            DEV_WRITE: begin
               in_sr_q <= {in_sr_q[22:0], din_s_q[1]};
               if (cnt_q == need_q - 5'h01) begin
                  cnt_q   <= 5'h00;
                  state_q <= DEV_CMD; // R14
                  unique case (rsel_q)
                     `RSEL_MODE:   mode_q   <= {in_sr_q[6:0], din_s_q[1]}; // R12
                     `RSEL_FILTER: filter_q <= {in_sr_q[6:0], din_s_q[1]};
                     default:      ;
                  endcase
               end else begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
            DEV_READ: begin
               if (cnt_q == need_q - 5'h01) begin
                  cnt_q   <= 5'h00;
                  state_q <= DEV_CMD; // R14
               end else begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
            default: state_q <= DEV_CMD;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // conversion result and ready flag; a new result wins over a clear but loses to a port reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdy_n_q <= 1'b1;
         data_q  <= `DATA_RESET;
      end else if (resync) begin
         // a port reset clears the pending result too, the whole part restarts
         rdy_n_q <= 1'b1; // R15
         data_q  <= `DATA_RESET;
      end else if (conv_done) begin
         rdy_n_q <= 1'b0; // R05 R09
         data_q  <= conv_data;
      end else if (update_soon) begin
         rdy_n_q <= 1'b1; // R06
      end else if (state_q == DEV_READ && rsel_q == `RSEL_DATA && rise && cnt_q == need_q - 5'h01) begin
         rdy_n_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output shifter loaded at end of a read command, shifted on falls
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         out_sr_q <= 24'h000000;
         dout_q   <= 1'b1;
      end else if (state_q == DEV_CMD && rise && cnt_q == 5'h07 && in_sr_q[`CMD_RNW_BIT-1]) begin
         unique case (in_sr_q[`CMD_RSEL_HI-1 -: 2]) // R11
            `RSEL_COMM_STATUS: out_sr_q <= {`STATUS_RESET & 8'h7F | {rdy_n_q, 7'h00}, 16'h0000}; // R10
            `RSEL_MODE:        out_sr_q <= {mode_q, 16'h0000};
            `RSEL_FILTER:      out_sr_q <= {filter_q, 16'h0000};
            `RSEL_DATA:        out_sr_q <= data_q;
         endcase
      end else if (fall) begin
         if (state_q == DEV_READ) begin
            dout_q   <= out_sr_q[23]; // R08
            out_sr_q <= {out_sr_q[22:0], 1'b0};
         end else begin
            dout_q <= rdy_n_q;
         end
      end else if (state_q != DEV_READ) begin
         dout_q <= rdy_n_q; // R05
      end
   end

   assign port.dout_o    = dout_q;
   assign port.dout_oe_n = cs_s_q[1]; // R09
endmodule

/* File: shared/adc_port_params.svh */
`ifndef ADC_PORT_PARAMS_SVH
`define ADC_PORT_PARAMS_SVH

// communications word layout, first bit sent is bit 7
`define CMD_WEN_BIT        7
`define CMD_ZERO_BIT       6
`define CMD_RSEL_HI        5
`define CMD_RSEL_LO        4
`define CMD_RNW_BIT        3
`define CMD_CREAD_BIT      2

// register_select_field codes
`define RSEL_COMM_STATUS   2'h0
`define RSEL_MODE          2'h1
`define RSEL_FILTER        2'h2
`define RSEL_DATA          2'h3

// reset values of the registers behind the port
`define STATUS_RESET       8'h8C
`define MODE_RESET         8'h02
`define FILTER_RESET       8'h04
`define DATA_RESET         24'h000000

// status bit that mirrors conversion ready (active low)
`define STATUS_RDY_BIT     7

// consecutive high data bits that reset the whole port
`define RESYNC_ONES        32

// link clock timing of the host end: 100 ns min high and low, 20 ns clk
`define SCLK_HALF_NS       100
`define CLK_PERIOD_NS      20
`define SCLK_HALF_CYC      ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: shared/adc_port_pkg.sv */
package adc_port_pkg;
   // device end sequencer
   typedef enum logic [1:0] {
      DEV_CMD   = 2'b00,
      DEV_READ  = 2'b01,
      DEV_WRITE = 2'b10
   } dev_state_t;

   // host end sequencer
   typedef enum logic [1:0] {
      HOST_IDLE  = 2'b00,
      HOST_LOW   = 2'b01,
      HOST_HIGH  = 2'b10,
      HOST_DONE  = 2'b11
   } host_state_t;
endpackage

/* File: shared/adc_port_if.sv */
interface adc_port_if;
   logic sclk;
   logic cs_n;
   logic din;
   logic dout_o;
   logic dout_oe_n;
   wire  dout_rdy;

   // pulled high when released, like the real open pin with a pull-up
   assign dout_rdy = dout_oe_n ? 1'b1 : dout_o;

   modport device (
      input  sclk,
      input  cs_n,
      input  din,
      output dout_o,
      output dout_oe_n
   );

   modport host (
      output sclk,
      output cs_n,
      output din,
      input  dout_rdy
   );
endinterface

/* File: hdl/adc_port_host.sv */
`include "adc_port_params.svh"

// host end: shifts out a frame of up to 32 bits while capturing the same number
module adc_port_host
   import adc_port_pkg::*;
#(
   parameter int MAX_BITS = 32
) (
   input  wire logic          clk,
   input  wire logic          reset_n,
   adc_port_if.host           port,
   input  wire logic          start,
   input  wire logic [5:0]    nbits,
   input  wire logic [31:0]   tx_data,
   input  wire logic          hold_cs,
   output logic               busy,
   output logic               done,
   output logic [31:0]        rx_data_q,
   output logic               ready_fall
);
   initial begin
      if (MAX_BITS != 32) $error("MAX_BITS must be 32");
   end

   host_state_t state_q;
   logic [2:0]  half_q;
   logic [5:0]  left_q;
   logic [31:0] tx_q;
   logic        sclk_q;
   logic        cs_n_q;
   logic        rdy_s1_q;
   logic        rdy_s2_q;
   logic        rdy_s3_q;

   assign port.sclk = sclk_q;
   assign port.cs_n = cs_n_q;
   assign port.din  = tx_q[31];
   assign busy      = (state_q != HOST_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // ready pin synchroniser; falling edge flags new data for the host
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdy_s1_q <= 1'b1;
         rdy_s2_q <= 1'b1;
         rdy_s3_q <= 1'b1;
      end else begin
         rdy_s1_q <= port.dout_rdy;
         rdy_s2_q <= rdy_s1_q;
         rdy_s3_q <= rdy_s2_q;
      end
   end

   assign ready_fall = rdy_s3_q && !rdy_s2_q && !cs_n_q && (state_q == HOST_IDLE); // R07

   ////////////////////////////////////////////////////////////////////////
   // clock divider and frame sequencer; data changes in the last clock of the high phase, one clock before sclk falls
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q   <= HOST_IDLE;
         half_q    <= 3'h0;
         left_q    <= 6'h00;
         tx_q      <= 32'h0000_0000;
         sclk_q    <= 1'b1;
         cs_n_q    <= 1'b1;
         rx_data_q <= 32'h0000_0000;
         done      <= 1'b0;
      end else begin
         done <= 1'b0;
         unique case (state_q)
            HOST_IDLE: begin
               if (start && nbits != 6'h00) begin
                  tx_q    <= tx_data;
                  left_q  <= nbits;
                  cs_n_q  <= 1'b0; // R03
                  half_q  <= 3'h0;
                  state_q <= HOST_LOW;
               end else if (!hold_cs) begin
                  cs_n_q <= 1'b1;
               end
            end
            HOST_LOW: begin
               sclk_q <= 1'b0;
               if (half_q == 3'(`SCLK_HALF_CYC - 1)) begin
                  half_q  <= 3'h0;
                  state_q <= HOST_HIGH;
               end else begin
                  half_q <= half_q + 3'h1;
               end
            end
            HOST_HIGH: begin
               if (half_q == 3'h0) begin
                  sclk_q <= 1'b1;
               end
               if (half_q == 3'(`SCLK_HALF_CYC - 1)) begin
                  // sample late in the high phase: the pin synchroniser trails the fall by five clocks
                  rx_data_q <= {rx_data_q[30:0], rdy_s2_q}; // R08
                  half_q    <= 3'h0;
                  tx_q   <= {tx_q[30:0], 1'b0};
                  left_q <= left_q - 6'h01;
                  // stopping between batches is legal: the device holds its place
                  state_q <= (left_q == 6'h01) ? HOST_DONE : HOST_LOW; // R01 R02
               end else begin
                  half_q <= half_q + 3'h1;
               end
            end
            HOST_DONE: begin
               done    <= 1'b1;
               if (!hold_cs) cs_n_q <= 1'b1;
               state_q <= HOST_IDLE;
            end
         endcase
      end
   end
endmodule

/* File: test/adc_serial_port_ready_props.sv */
module adc_serial_port_ready_props (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic dout_o,
   input wire logic dout_oe_n,
   input wire logic dout_rdy,
   input wire logic conv_done,
   input wire logic update_soon,
   input wire logic port_reset
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       sclk_q;
   logic [5:0] ones_q;

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   ////////////////////////////////////////////////////////////////
   // raw link clock edge finder, no synchroniser lag on purpose
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) sclk_q <= 1'b1;
      else sclk_q <= sclk;
   end

   // run of high data bits, saturates so a long run never wraps
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) ones_q <= 6'h00;
      else if (sclk && !sclk_q) ones_q <= !din ? 6'h00 : (ones_q == 6'h3F ? ones_q : ones_q + 6'h01);
   end

   ////////////////////////////////////////////////////////////////
   sequence sel_held;
      (!cs_n) [*4];
   endsequence
   sequence desel_held;
      cs_n [*4];
   endsequence

   a_drive_on_select: assert property ($fell(cs_n) |-> ##[1:5] !dout_oe_n)
      else $error("pin not driven after select");
   a_release_idle: assert property (desel_held |-> dout_oe_n)
      else $error("pin driven while deselected");
   a_release_soon: assert property ($rose(cs_n) |-> ##[0:4] dout_oe_n)
      else $error("pin not released after deselect");
   a_bit_stable_high: assert property ($rose(sclk) && !cs_n |=> $stable(dout_o) [*2])
      else $error("output bit moved near rising clock");
   a_ready_falls: assert property (conv_done ##1 sel_held |-> !dout_rdy)
      else $error("ready pin not low after conversion");
   a_ready_returns: assert property (update_soon ##1 sel_held |-> dout_rdy)
      else $error("ready pin not high before update");
   a_resync_fires: assert property (sclk && !sclk_q && din && ones_q == 6'd31 |-> ##[1:8] port_reset)
      else $error("no port reset after long high run");
   a_resync_only: assert property (port_reset |-> ones_q >= 6'd32)
      else $error("port reset without long high run");
endmodule

/* File: test/adc_serial_port_ready_bench.sv */
module adc_serial_port_ready_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk, reset_n, start, hold_cs, busy, done, ready_fall;
   logic        conv_done, update_soon, port_reset;
   logic [5:0]  nbits;
   logic [31:0] tx_data, rx_data_q;
   logic [23:0] conv_data;
   logic [7:0]  mode_q, filter_q, v, w;
   integer      seed, fail_count, num_checks, cycles;

   adc_port_if port_if ();

   adc_port_host i_adc_port_host (.clk(clk), .reset_n(reset_n), .port(port_if), .start(start), .nbits(nbits),
      .tx_data(tx_data), .hold_cs(hold_cs), .busy(busy), .done(done), .rx_data_q(rx_data_q),
      .ready_fall(ready_fall));
   adc_port_device i_adc_port_device (.clk(clk), .reset_n(reset_n), .port(port_if), .conv_done(conv_done),
      .update_soon(update_soon), .conv_data(conv_data), .mode_q(mode_q), .filter_q(filter_q),
      .port_reset(port_reset));
   adc_serial_port_ready_props i_adc_serial_port_ready_props (.clk(clk), .reset_n(reset_n),
      .sclk(port_if.sclk), .cs_n(port_if.cs_n), .din(port_if.din), .dout_o(port_if.dout_o),
      .dout_oe_n(port_if.dout_oe_n), .dout_rdy(port_if.dout_rdy), .conv_done(conv_done),
      .update_soon(update_soon), .port_reset(port_reset));

   ////////////////////////////////////////////////////////////////
   always #10 clk = ~clk;

   // hang guard, a full run is well under this
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 40000) begin
         fail_count = fail_count + 1;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////
   function automatic logic [7:0] status_exp(input logic rdy);
      status_exp = rdy ? 8'h0C : 8'h8C;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // always 32 bits, so no doubt about which end of tx_data goes first
   task automatic frame(input logic [31:0] tx, input logic hold);
      int n;
      @(negedge clk);
      start = 1'b1;
      tx_data = tx;
      hold_cs = hold;
      @(negedge clk);
      start = 1'b0;
      check(busy, 1'b1);
      n = 0;
      while (done !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 2000) check(1'b0, 1'b1);
      check(busy, 1'b0);
   endtask

   task automatic pulse(input bit upd);
      @(negedge clk);
      if (upd) update_soon = 1'b1;
      else conv_done = 1'b1;
      @(negedge clk);
      update_soon = 1'b0;
      conv_done = 1'b0;
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      int n;
      clk = 1'b0; reset_n = 1'b0; start = 1'b0; nbits = 6'h20; tx_data = 32'h0; hold_cs = 1'b0;
      conv_done = 1'b0; update_soon = 1'b0; conv_data = 24'h0; seed = 32'h2C43;
      fail_count = 0; num_checks = 0; cycles = 0;
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      check(mode_q, 8'h02);
      check(filter_q, 8'h04);
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         w = 8'($random(seed));
         if (i == 0) begin
            v = 8'h00;
            w = 8'hFF;
         end
         // leading ones park the command, then the write spans a clock pause
         frame({20'hFFFFF, 8'h10, v[7:4]}, 1'b1);
         frame({v[3:0], 8'h20, w, 12'hFFF}, 1'b1);
         check(mode_q, v);
         check(filter_q, w);
         frame(32'h18002800, 1'b1);
         check(rx_data_q[23:16], v);
         check(rx_data_q[7:0], w);
         conv_data = 24'($random(seed));
         pulse(1'b0);
         // the interrupt edge is a one-clock pulse, so count it at every clock
         n = 0;
         repeat (6) begin
            @(negedge clk);
            if (ready_fall === 1'b1) n++;
         end
         check(n, 1);
         check(port_if.dout_rdy, 1'b0);
         frame(32'h08000000, 1'b1);
         check(rx_data_q[23:16], status_exp(1'b1));
         frame(32'h38000000, i[0]);
         check(rx_data_q[23:0], conv_data);
         // even passes leave the port deselected while the flag moves
         pulse(1'b0);
         repeat (4) @(negedge clk);
         pulse(1'b1);
         repeat (6) @(negedge clk);
         check(port_if.dout_rdy, 1'b1);
         frame(32'h08000000, 1'b1);
         check(rx_data_q[23:16], status_exp(1'b0));
      end
      // a pending result must be cleared by the port reset as well
      pulse(1'b0);
      // reset pulse is short, so watch for it while the frame runs
      n = 0;
      fork
         frame(32'hFFFFFFFF, 1'b1);
         while (port_reset !== 1'b1 && n < 600) begin
            @(negedge clk);
            n++;
         end
      join
      check(n < 600, 1'b1);
      check(mode_q, 8'h02);
      check(filter_q, 8'h04);
      repeat (2) @(negedge clk);
      check(port_if.dout_rdy, 1'b1);
      frame(32'h18002800, 1'b0);
      check(rx_data_q[23:16], 8'h02);
      check(rx_data_q[7:0], 8'h04);
      complete_run();
   end
endmodule
